// *** aibc_irq_ctrl.v ***
// aux irq group, core enable gating and breakpoints behind AXI4-Lite
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "aibc_consts.vh"
module aibc_irq_ctrl (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire [11:0] s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output wire        s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output wire        s_axi_wready_o,
  output wire [1:0]  s_axi_bresp_o,
  output wire        s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [11:0] s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output wire        s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0]  s_axi_rresp_o,
  output wire        s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  input  wire        one_hz_tick_i,
  input  wire        accumulator_done_i,
  input  wire        accum_lsb_read_i,
  input  wire        conversion_done_i,
  input  wire        conv_lsb_read_i,
  input  wire        ms_tick_i,
  input  wire        serial_tx_i,
  input  wire        serial_rx_or_twowire_i,
  input  wire        analog_undervolt_i,
  input  wire        digital_undervolt_i,
  input  wire        uart_a_rx_done_i,
  input  wire        uart_a_tx_done_i,
  input  wire        uart_b_req_i,
  input  wire        timer_two_req_i,
  input  wire        timer_one_overflow_i,
  input  wire        timer_zero_overflow_i,
  input  wire        ext_irq_pin_zero_n_i,
  input  wire        ext_irq_pin_one_n_i,
  input  wire [15:0] mon_addr_i,
  input  wire        mon_data_i,
  input  wire        mon_prog_i,
  output wire        aux_irq_req_o,
  output wire [15:0] aux_vector_o,
  output wire [6:0]  core_irq_req_o,
  output wire        conv_write_block_o
);
  // register index decode shared by read and write paths
  function map_hit;
    input [11:0] a;
    input [7:0]  idx;
    begin
      map_hit = (a[11:10] == 2'h0) && (a[1:0] == 2'h0) &&
                (a[9:2] == idx);
    end
  endfunction

  function map_any;
    input [11:0] a;
    begin
      map_any = map_hit(a, `AIBC_IDX_MEMORY_CONFIG_INDEX) ||
                map_hit(a, `AIBC_IDX_POLL) ||
                map_hit(a, `AIBC_IDX_PEND) ||
                map_hit(a, `AIBC_IDX_AMASK) ||
                map_hit(a, `AIBC_IDX_AFLAG) ||
                map_hit(a, `AIBC_IDX_CMASK) ||
                map_hit(a, `AIBC_IDX_BCTL) ||
                map_hit(a, `AIBC_IDX_BLO) ||
                map_hit(a, `AIBC_IDX_BHI) ||
                map_hit(a, `AIBC_IDX_XCTL);
    end
  endfunction

  // bus slave state
  reg        awready_q;
  reg        wready_q;
  reg        aw_full_q;
  reg        w_full_q;
  reg [11:0] awaddr_q;
  reg [7:0]  wdata_q;
  reg        wlane_q;
  reg        bvalid_q;
  reg [1:0]  bresp_q;
  reg        arready_q;
  reg        rd_pend_q;
  reg [11:0] araddr_q;
  reg        rvalid_q;
  reg [7:0]  rdata_q;
  reg [1:0]  rresp_q;

  // software registers
  reg [7:0]  aux_mask_q;
  reg [7:0]  core_mask_q;
  reg [7:0]  ext_ctrl_q;
  reg [7:0]  mem_cfg_q;
  reg [7:0]  brk_lo_q;
  reg [7:0]  brk_hi_q;
  reg        read_view_select_q;

  // sources and outputs
  reg        accum_done_q;
  reg        conv_done_q;
  reg [1:0]  ext0_sync_q;
  reg [1:0]  ext1_sync_q;
  reg        aux_req_q;
  reg [6:0]  core_req_q;
  reg [15:0] aux_vec_q;

  wire       wr_en;
  wire [7:0] aux_raw;
  wire [7:0] aux_flags;
  wire [3:0] pend_idx;
  wire [7:0] core_src;
  wire       bsel;
  wire [`AIBC_NUM_BP-1:0] bp_load;
  wire [`AIBC_NUM_BP-1:0] bp_clear;
  wire [`AIBC_NUM_BP-1:0] bp_space;
  wire [`AIBC_NUM_BP-1:0] bp_arm;
  wire [`AIBC_NUM_BP-1:0] bp_hit;
  wire       any_hit;
  reg  [7:0] rd_mux;
  reg  [3:0] pend_calc;
  integer    k;

  assign wr_en = aw_full_q && w_full_q && !bvalid_q && wlane_q;

  // write channel: address and data taken in either order
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= `AIBC_RST8;
      wlane_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `AIBC_RESP_OK;
    end else begin
      if (s_axi_awvalid_i && awready_q) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_i;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid_i && wready_q) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata_i[7:0];
        wlane_q  <= s_axi_wstrb_i[0];
        wready_q <= 1'b0;
      end
      if (aw_full_q && w_full_q && !bvalid_q) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= map_any(awaddr_q) ? `AIBC_RESP_OK
                                       : `AIBC_RESP_ERR;
      end
      if (bvalid_q && s_axi_bready_i) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // read channel: data one cycle after the address is taken
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      arready_q <= 1'b1;
      rd_pend_q <= 1'b0;
      araddr_q  <= 12'h000;
      rvalid_q  <= 1'b0;
      rdata_q   <= `AIBC_RST8;
      rresp_q   <= `AIBC_RESP_OK;
    end else begin
      if (s_axi_arvalid_i && arready_q) begin
        araddr_q  <= s_axi_araddr_i;
        arready_q <= 1'b0;
        rd_pend_q <= 1'b1;
      end
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_mux;
        rresp_q   <= map_any(araddr_q) ? `AIBC_RESP_OK
                                       : `AIBC_RESP_ERR;
      end
      if (rvalid_q && s_axi_rready_i) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // software register writes
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aux_mask_q         <= `AIBC_RST8;
      core_mask_q        <= `AIBC_RST8;
      ext_ctrl_q         <= `AIBC_RST8;
      mem_cfg_q          <= `AIBC_RST8;
      brk_lo_q           <= `AIBC_RST8;
      brk_hi_q           <= `AIBC_RST8;
      read_view_select_q <= 1'b0;
    end else if (wr_en) begin
      if (map_hit(awaddr_q, `AIBC_IDX_AMASK))
        aux_mask_q <= wdata_q;
      if (map_hit(awaddr_q, `AIBC_IDX_CMASK))
        core_mask_q <= wdata_q;
      if (map_hit(awaddr_q, `AIBC_IDX_XCTL))
        ext_ctrl_q <= wdata_q;
      if (map_hit(awaddr_q, `AIBC_IDX_MEMORY_CONFIG_INDEX))
        mem_cfg_q <= wdata_q;
      if (map_hit(awaddr_q, `AIBC_IDX_BLO))
        brk_lo_q <= wdata_q;
      if (map_hit(awaddr_q, `AIBC_IDX_BHI))
        brk_hi_q <= wdata_q;
      if (map_hit(awaddr_q, `AIBC_IDX_POLL))
        read_view_select_q <= wdata_q[`AIBC_P_READ_VIEW_SELECT];
    end
  end

  // summation and conversion requests hold until the low byte is read;
  // a completion in the read cycle wins so no result is lost
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      accum_done_q <= 1'b0;
      conv_done_q  <= 1'b0;
    end else begin
      if (accumulator_done_i)
        accum_done_q <= 1'b1;
      else if (accum_lsb_read_i)
        accum_done_q <= 1'b0;
      if (conversion_done_i)
        conv_done_q <= 1'b1;
      else if (conv_lsb_read_i)
        conv_done_q <= 1'b0;
    end
  end

  // external pins are asynchronous: two flops before use
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext0_sync_q <= 2'h3;
      ext1_sync_q <= 2'h3;
    end else begin
      ext0_sync_q <= {ext0_sync_q[0], ext_irq_pin_zero_n_i};
      ext1_sync_q <= {ext1_sync_q[0], ext_irq_pin_one_n_i};
    end
  end

  // raw aux requests in their fixed bit positions
  assign aux_raw[`AIBC_A_SEC]  = one_hz_tick_i;
  assign aux_raw[`AIBC_A_SUM]  = accum_done_q;
  assign aux_raw[`AIBC_A_CONV] = conv_done_q;
  assign aux_raw[`AIBC_A_MS]   = ms_tick_i;
  assign aux_raw[`AIBC_A_STX]  = serial_tx_i;
  assign aux_raw[`AIBC_A_SRX]  = serial_rx_or_twowire_i;
  assign aux_raw[`AIBC_A_ALV]  = analog_undervolt_i;
  assign aux_raw[`AIBC_A_DLV]  = digital_undervolt_i | any_hit;

  assign aux_flags = aux_raw & aux_mask_q;

  // lowest set bit has priority; code is bit number plus one
  always @* begin
    pend_calc = 4'h0;
    for (k = 7; k >= 0; k = k - 1)
      if (aux_flags[k])
        pend_calc = k[3:0] + 4'h1;
  end
  assign pend_idx = pend_calc;

  // core sources in core mask bit order
  assign core_src[`AIBC_C_GATE]  = 1'b0;
  assign core_src[`AIBC_C_UARTB] = uart_b_req_i;
  assign core_src[`AIBC_C_T2]    = timer_two_req_i;
  assign core_src[`AIBC_C_UARTA] = uart_a_rx_done_i |
                                   uart_a_tx_done_i;
  assign core_src[`AIBC_C_T1]    = timer_one_overflow_i;
  assign core_src[`AIBC_C_X1]    = ~ext1_sync_q[1];
  assign core_src[`AIBC_C_T0]    = timer_zero_overflow_i;
  assign core_src[`AIBC_C_X0]    = ~ext0_sync_q[1];

  // request outputs, all registered
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aux_req_q  <= 1'b0;
      core_req_q <= 7'h00;
      aux_vec_q  <= 16'h0000;
    end else begin
      // aux group ignores the global gate
      aux_req_q  <= ext_ctrl_q[`AIBC_X_AUXGATE] && (|aux_flags);
      // global gate overrides every core mask bit
      core_req_q <= core_mask_q[`AIBC_C_GATE] ?
                    (core_src[6:0] & core_mask_q[6:0]) : 7'h00;
      aux_vec_q  <= `AIBC_AUX_VECTOR;
    end
  end

  // breakpoints, chosen by the index register
  assign bsel = mem_cfg_q[`AIBC_M_BSEL];
  assign any_hit = |bp_hit;

  genvar g;
  generate
    for (g = 0; g < `AIBC_NUM_BP; g = g + 1) begin : g_bp
      // any control write loads the selected unit
      assign bp_load[g] = wr_en && (bsel == g) &&
                          map_hit(awaddr_q, `AIBC_IDX_BCTL);
      // writing 1 to the hit bit clears that unit only
      assign bp_clear[g] = bp_load[g] && wdata_q[`AIBC_B_HIT];
      aibc_break_unit u_bp (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (rst_i),
        .load_i     (bp_load[g]),
        .addr_i     ({brk_hi_q, brk_lo_q}),
        .space_i    (wdata_q[`AIBC_B_SPACE]),
        .arm_i      (wdata_q[`AIBC_B_ARM]),
        .clear_i    (bp_clear[g]),
        .mon_addr_i (mon_addr_i),
        .mon_data_i (mon_data_i),
        .mon_prog_i (mon_prog_i),
        .space_o    (bp_space[g]),
        .arm_o      (bp_arm[g]),
        .hit_o      (bp_hit[g])
      );
    end
  endgenerate

  // read data; poll bit 0 is write-only, so the poll register
  // shows the opposite view of the mask register
  always @* begin
    rd_mux = 8'h00;
    if (map_hit(araddr_q, `AIBC_IDX_AMASK))
      rd_mux = read_view_select_q ? aux_mask_q : aux_raw;
    if (map_hit(araddr_q, `AIBC_IDX_POLL))
      rd_mux = read_view_select_q ? aux_raw : aux_mask_q;
    if (map_hit(araddr_q, `AIBC_IDX_AFLAG))
      rd_mux = aux_flags;
    if (map_hit(araddr_q, `AIBC_IDX_PEND))
      rd_mux = {4'h0, pend_idx};
    if (map_hit(araddr_q, `AIBC_IDX_CMASK))
      rd_mux = core_mask_q;
    if (map_hit(araddr_q, `AIBC_IDX_BCTL))
      rd_mux = {any_hit, 5'h00, bp_space[bsel], bp_arm[bsel]};
    if (map_hit(araddr_q, `AIBC_IDX_BLO))
      rd_mux = brk_lo_q;
    if (map_hit(araddr_q, `AIBC_IDX_BHI))
      rd_mux = brk_hi_q;
    if (map_hit(araddr_q, `AIBC_IDX_XCTL))
      rd_mux = ext_ctrl_q;
    if (map_hit(araddr_q, `AIBC_IDX_MEMORY_CONFIG_INDEX))
      rd_mux = mem_cfg_q;
  end

  assign s_axi_awready_o    = awready_q;
  assign s_axi_wready_o     = wready_q;
  assign s_axi_bresp_o      = bresp_q;
  assign s_axi_bvalid_o     = bvalid_q;
  assign s_axi_arready_o    = arready_q;
  assign s_axi_rdata_o      = {24'h000000, rdata_q};
  assign s_axi_rresp_o      = rresp_q;
  assign s_axi_rvalid_o     = rvalid_q;
  assign aux_irq_req_o      = aux_req_q;
  assign aux_vector_o       = aux_vec_q;
  assign core_irq_req_o     = core_req_q;
  // converter must not overwrite its output while flagged
  assign conv_write_block_o = conv_done_q;
endmodule // aibc_irq_ctrl
`default_nettype wire

// *** aibc_consts.vh ***
// register map, field positions and reset values of the irq block
`ifndef AIBC_CONSTS_VH
`define AIBC_CONSTS_VH
// register indices; byte address is four times the index
`define AIBC_IDX_MEMORY_CONFIG_INDEX    8'h95
`define AIBC_IDX_POLL    8'hA4
`define AIBC_IDX_PEND    8'hA5
`define AIBC_IDX_AMASK   8'hA6
`define AIBC_IDX_AFLAG   8'hA7
`define AIBC_IDX_CMASK   8'hA8
`define AIBC_IDX_BCTL    8'hA9
`define AIBC_IDX_BLO     8'hAA
`define AIBC_IDX_BHI     8'hAB
`define AIBC_IDX_XCTL    8'hD8
`define AIBC_RST8        8'h00
// aux source bits
`define AIBC_A_SEC       7
`define AIBC_A_SUM       6
`define AIBC_A_CONV      5
`define AIBC_A_MS        4
`define AIBC_A_STX       3
`define AIBC_A_SRX       2
`define AIBC_A_ALV       1
`define AIBC_A_DLV       0
// core mask bits
`define AIBC_C_GATE      7
`define AIBC_C_UARTB     6
`define AIBC_C_T2        5
`define AIBC_C_UARTA     4
`define AIBC_C_T1        3
`define AIBC_C_X1        2
`define AIBC_C_T0        1
`define AIBC_C_X0        0
// other fields
`define AIBC_X_AUXGATE   4
`define AIBC_P_READ_VIEW_SELECT     0
`define AIBC_B_HIT       7
`define AIBC_B_SPACE     1
`define AIBC_B_ARM       0
`define AIBC_M_BSEL      0
`define AIBC_NUM_BP      2
`define AIBC_AUX_VECTOR  16'h0033
`define AIBC_RESP_OK     2'h0
`define AIBC_RESP_ERR    2'h2
`endif

// *** aibc_break_unit.v ***
// one hardware breakpoint: stored address, space, arm and hit flag
`timescale 1ns/10ps
`default_nettype none
module aibc_break_unit (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire        load_i,
  input  wire [15:0] addr_i,
  input  wire        space_i,
  input  wire        arm_i,
  input  wire        clear_i,
  input  wire [15:0] mon_addr_i,
  input  wire        mon_data_i,
  input  wire        mon_prog_i,
  output wire        space_o,
  output wire        arm_o,
  output wire        hit_o
);
  reg [15:0] addr_q;
  reg        space_q;
  reg        arm_q;
  reg        hit_q;
  wire       match;

  // 0 watches data accesses, 1 watches program fetches
  assign match = arm_q && (mon_addr_i == addr_q) &&
                 (space_q ? mon_prog_i : mon_data_i);

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q  <= 16'h0000;
      space_q <= 1'b0;
      arm_q   <= 1'b0;
      hit_q   <= 1'b0;
    end else begin
      if (load_i) begin
        addr_q  <= addr_i;
        space_q <= space_i;
        arm_q   <= arm_i;
      end
      // a match in the clearing cycle keeps the flag set
      if (match)
        hit_q <= 1'b1;
      else if (clear_i)
        hit_q <= 1'b0;
    end
  end

  assign space_o = space_q;
  assign arm_o   = arm_q;
  assign hit_o   = hit_q;
endmodule // aibc_break_unit
`default_nettype wire

// *** aibc_irq_ctrl_checker.sv ***
// port-level assertions for the aux irq controller
`timescale 1ns/10ps
`default_nettype none
module aibc_irq_ctrl_checker (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        conversion_done_i,
  input wire logic        conv_lsb_read_i,
  input wire logic        uart_a_rx_done_i,
  input wire logic        uart_a_tx_done_i,
  input wire logic        timer_one_overflow_i,
  input wire logic        timer_zero_overflow_i,
  input wire logic        ext_irq_pin_zero_n_i,
  input wire logic [15:0] aux_vector_o,
  input wire logic [6:0]  core_irq_req_o,
  input wire logic        conv_write_block_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  a_write_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response late");
  a_read_answer: assert property (s_rd_take |-> ##[1:3] s_axi_rvalid_o)
    else $error("read response late");
  a_resp_blocks: assert property (s_axi_bvalid_o |->
      !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while response pending");
  a_rdata_upper: assert property (s_axi_rvalid_o |->
      s_axi_rdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_vector_fixed: assert property (!$past(rst_i) |->
      aux_vector_o == 16'h0033)
    else $error("aux vector wrong");
  a_conv_set: assert property (conversion_done_i |=> conv_write_block_o)
    else $error("conversion latch not set");
  a_conv_clear: assert property (conv_lsb_read_i && !conversion_done_i
      |=> !conv_write_block_o)
    else $error("conversion latch not cleared");
  a_conv_hold: assert property (conv_write_block_o && !conv_lsb_read_i
      |=> conv_write_block_o)
    else $error("conversion latch dropped");
  a_uart_pass: assert property (core_irq_req_o[4] |->
      $past(uart_a_rx_done_i || uart_a_tx_done_i))
    else $error("uart request without cause");
  a_timer_pass: assert property (
      core_irq_req_o[3] || core_irq_req_o[1] |->
      (!core_irq_req_o[3] || $past(timer_one_overflow_i)) &&
      (!core_irq_req_o[1] || $past(timer_zero_overflow_i)))
    else $error("timer request without overflow");
  a_pin_pass: assert property (core_irq_req_o[0] |->
      !$past(ext_irq_pin_zero_n_i, 3))
    else $error("pin request without low pin");
endmodule // aibc_irq_ctrl_checker
bind aibc_irq_ctrl aibc_irq_ctrl_checker u_chk (.*);
`default_nettype wire

// *** aibc_irq_ctrl_tb.sv ***
// self-checking bench for the aux irq controller
`timescale 1ns/10ps
`default_nettype none
`include "aibc_consts.vh"
module aibc_irq_ctrl_tb;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, seed;
  logic [7:0]  aux_src, core_src, m, r, k, s;
  logic [6:0]  e;
  logic [3:0]  strb;
  wire  [15:0] vec;
  logic        acc_set, acc_clr, cv_set, cv_clr, mdata, mprog;
  logic [15:0] maddr;
  wire         awready, wready, bvalid, arready, rvalid, auxreq, cblk;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [6:0]  creq;
  logic [33:0] rd_q[$];
  logic [33:0] wr_q[$];
  int          bad_count, check_count, cyc;
  logic [7:0]  ridx [7] = '{`AIBC_IDX_AMASK, `AIBC_IDX_AFLAG, `AIBC_IDX_CMASK,
    `AIBC_IDX_BCTL, `AIBC_IDX_BLO, `AIBC_IDX_BHI, `AIBC_IDX_PEND};

  aibc_irq_ctrl dut (
    .ref_clk_i(clk), .rst_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .one_hz_tick_i(aux_src[7]), .accumulator_done_i(acc_set),
    .accum_lsb_read_i(acc_clr), .conversion_done_i(cv_set),
    .conv_lsb_read_i(cv_clr), .ms_tick_i(aux_src[4]),
    .serial_tx_i(aux_src[3]), .serial_rx_or_twowire_i(aux_src[2]),
    .analog_undervolt_i(aux_src[1]), .digital_undervolt_i(aux_src[0]),
    .uart_a_rx_done_i(core_src[4]), .uart_a_tx_done_i(core_src[7]),
    .uart_b_req_i(core_src[6]), .timer_two_req_i(core_src[5]),
    .timer_one_overflow_i(core_src[3]), .timer_zero_overflow_i(core_src[1]),
    .ext_irq_pin_zero_n_i(core_src[0]), .ext_irq_pin_one_n_i(core_src[2]),
    .mon_addr_i(maddr), .mon_data_i(mdata), .mon_prog_i(mprog),
    .aux_irq_req_o(auxreq), .aux_vector_o(vec), .core_irq_req_o(creq),
    .conv_write_block_o(cblk)
  );

  function automatic logic [31:0] nxt(input logic [31:0] v);
    for (int i = 0; i < 16; i++) begin
      v = v[0] ? (v >> 1) ^ 32'h80200003 : v >> 1;
    end
    return v;
  endfunction

  // highest priority is the lowest set bit, coded as bit index plus one
  function automatic logic [7:0] pend(input logic [7:0] f);
    pend = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      if (f[b]) pend = 8'(b + 1);
    end
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] er = `AIBC_RESP_OK);
    @(posedge clk);
    wr_q.push_back({32'h0, er});
    awaddr  <= {2'h0, idx, 2'h0};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] er = `AIBC_RESP_OK);
    @(posedge clk);
    rd_q.push_back({er, 24'h0, d});
    araddr  <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // results are compared where they appear, against the oldest note
  always @(posedge clk) begin
    if (!rst && rvalid && rready) chk({rresp, rdata}, rd_q.pop_front());
    if (!rst && bvalid && bready) chk(bresp, wr_q.pop_front());
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 12'h000; araddr = 12'h000;
    wdata = 32'h0; aux_src = 8'h00; core_src = 8'h05; acc_set = 1'b0;
    acc_clr = 1'b0; cv_set = 1'b0; cv_clr = 1'b0; mdata = 1'b0;
    mprog = 1'b0; maddr = 16'h0000; seed = 32'h576aac15; strb = 4'hF;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (ridx[i]) rd(ridx[i], 8'h00);
    rd(8'h10, 8'h00, `AIBC_RESP_ERR);
    wr(8'h10, 8'hFF, `AIBC_RESP_ERR);
    chk(vec, `AIBC_AUX_VECTOR);
    $display("test reset done");
    wr(`AIBC_IDX_XCTL, 8'h10);
    for (int i = 0; i < 4; i++) begin
      seed = nxt(seed);
      m = seed[7:0];
      r = seed[15:8] & 8'h9F;
      aux_src <= r;
      wr(`AIBC_IDX_AMASK, m);
      wr(`AIBC_IDX_POLL, {7'h0, i[0]});
      rd(`AIBC_IDX_AMASK, i[0] ? m : r);
      rd(`AIBC_IDX_POLL, i[0] ? r : m);
      rd(`AIBC_IDX_AFLAG, r & m);
      rd(`AIBC_IDX_PEND, pend(r & m));
      chk(auxreq, |(r & m));
    end
    aux_src <= 8'h01;
    wr(`AIBC_IDX_AMASK, 8'h01);
    repeat (2) @(posedge clk);
    chk(auxreq, 1'b1);
    wr(`AIBC_IDX_XCTL, 8'h00);
    repeat (2) @(posedge clk);
    chk(auxreq, 1'b0);
    $display("test aux done");
    aux_src <= 8'h00;
    wr(`AIBC_IDX_AMASK, 8'hFF);
    acc_set <= 1'b1;
    cv_set <= 1'b1;
    @(posedge clk);
    acc_set <= 1'b0;
    cv_set <= 1'b0;
    rd(`AIBC_IDX_AFLAG, 8'h60);
    chk(cblk, 1'b1);
    acc_clr <= 1'b1;
    @(posedge clk);
    acc_clr <= 1'b0;
    rd(`AIBC_IDX_AFLAG, 8'h20);
    cv_clr <= 1'b1;
    @(posedge clk);
    cv_clr <= 1'b0;
    rd(`AIBC_IDX_AFLAG, 8'h00);
    chk(cblk, 1'b0);
    $display("test latches done");
    strb <= 4'h0;
    wr(`AIBC_IDX_AMASK, 8'h00);
    strb <= 4'hF;
    rd(`AIBC_IDX_AMASK, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      seed = nxt(seed);
      k = {i[0], seed[6:0]};
      s = seed[15:8];
      e = {s[6], s[5], s[4] | s[7], s[3], ~s[2], s[1], ~s[0]};
      core_src <= s;
      wr(`AIBC_IDX_CMASK, k);
      repeat (4) @(posedge clk);
      chk(creq, k[7] ? k[6:0] & e : 7'h00);
      rd(`AIBC_IDX_CMASK, k);
    end
    $display("test core done");
    wr(`AIBC_IDX_MEMORY_CONFIG_INDEX, 8'h00);
    wr(`AIBC_IDX_BLO, 8'h34);
    wr(`AIBC_IDX_BHI, 8'h12);
    wr(`AIBC_IDX_BCTL, 8'h03);
    maddr <= 16'h1234;
    mdata <= 1'b1;
    @(posedge clk);
    mdata <= 1'b0;
    rd(`AIBC_IDX_AFLAG, 8'h00);
    mprog <= 1'b1;
    @(posedge clk);
    mprog <= 1'b0;
    rd(`AIBC_IDX_AFLAG, 8'h01);
    rd(`AIBC_IDX_BCTL, 8'h83);
    wr(`AIBC_IDX_BCTL, 8'h03);
    rd(`AIBC_IDX_AFLAG, 8'h01);
    wr(`AIBC_IDX_MEMORY_CONFIG_INDEX, 8'h01);
    wr(`AIBC_IDX_BCTL, 8'h80);
    rd(`AIBC_IDX_AFLAG, 8'h01);
    wr(`AIBC_IDX_MEMORY_CONFIG_INDEX, 8'h00);
    wr(`AIBC_IDX_BCTL, 8'h82);
    rd(`AIBC_IDX_AFLAG, 8'h00);
    $display("test breakpoint done");
    summarize();
  end
endmodule // aibc_irq_ctrl_tb
`default_nettype wire
